// >>> src/vme_slave_config.sv
// vme slave front end: jtag path, a24 configuration registers, a32 window
// assumes vme pins are asynchronous; trigger and level inputs share clk_in
`timescale 1ns/10ps
module vme_slave_config
    import vme_cfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        as_n_in,
    input  wire logic [1:0]  ds_n_in,
    input  wire logic        write_n_in,
    input  wire logic [5:0]  am_in,
    input  wire logic [31:2] addr_in,
    input  wire logic [31:0] data_in,
    input  wire logic [4:0]  ga_n_in,
    input  wire logic [7:0]  mode_switch_in,
    input  wire logic        fallback_revision_select_in,
    input  wire logic        run_mode_in,
    input  wire logic [7:0]  block_level_in,
    input  wire logic [7:0]  master_level_in,
    input  wire logic        trigger_in,
    input  wire logic        synchronous_reset_broadcast_in,
    output logic [31:0]      data_out,
    output logic             data_oe_n_out,
    output logic             dtack_out,
    output logic             dtack_oe_n_out,
    output logic             a32_read_out,
    output logic             jtag_tck_out,
    output logic             jtag_tms_out,
    output logic             jtag_tdi_out,
    output logic             clk_source_osc_out,
    output logic             config_revision_out,
    output logic             optic_low_power_select_out,
    output logic             optic_module_select_n_out,
    output logic             optic_reset_n_out,
    output logic             p0_trigger_out,
    output logic             synchronous_reset_broadcast_out,
    output cfg_t             cfg_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_SKIP} state_t;

    pin_t        pin_raw;
    pin_t        pin;
    state_t      st_q, st_d;
    logic [31:0] crate_q, crate_d;
    logic [31:0] optic_q, optic_d;
    logic [31:0] irq_q, irq_d;
    logic [31:0] trig_q, trig_d;
    logic [31:0] a32_q, a32_d;
    logic [31:0] block_q, block_d;
    logic [31:0] format_q, format_d;
    logic [31:0] vopt_q, vopt_d;
    logic [31:0] clksel_q, clksel_d;
    logic [31:0] data_d;
    logic        data_oe_n_d;
    logic        dtack_oe_n_d;
    logic        a32_rd_d;
    logic        jtag_go_q, jtag_go_d;
    logic        jtag_tms_q, jtag_tms_d;
    logic        jtag_tdi_q, jtag_tdi_d;
    logic        clk_osc_d;
    logic        rev_d;
    logic        p0_trig_d;
    logic        p0_sync_d;
    logic [4:0]  geo;
    logic        strobe;
    logic        released;
    am_class_t   cls;
    logic        base_ok;
    logic [7:0]  ofs;
    logic        ofs_known;
    logic [31:0] rword;
    logic        jtag_hit;
    logic        reg_hit;
    logic        a32_hit;
    logic        reg_wr;

    assign pin_raw = '{as_n: as_n_in, ds_n: ds_n_in, write_n: write_n_in,
                       am: am_in, addr: addr_in, data: data_in,
                       ga_n: ga_n_in, sw: mode_switch_in,
                       fallback: fallback_revision_select_in};

    pin_sync #(
        .W       ($bits(pin_t)),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (pin_raw),
        .q_out    (pin)
    );

    jtag_step u_jtag (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .step_in  (jtag_go_q),
        .tms_in   (jtag_tms_q),
        .tdi_in   (jtag_tdi_q),
        .tck_out  (jtag_tck_out),
        .tms_out  (jtag_tms_out),
        .tdi_out  (jtag_tdi_out)
    );

    // address decode
    always_comb begin
        // geo lines are active low, so a non-vme64x crate gives zero
        geo = pin.sw[SW_A24_BIT] ? pin.sw[4:0] : ~pin.ga_n; // RL2
        strobe   = !pin.as_n && (pin.ds_n != 2'h3);
        released = (pin.ds_n == 2'h3);
        cls      = am_class(pin.am); // RL4
        base_ok  = (pin.addr[23:19] == geo); // RL10
        ofs      = {pin.addr[7:2], 2'h0};
        // address bits 31..24 ignored on the jtag path
        jtag_hit = (cls == AM_JTAG) && base_ok && !pin.write_n // RL5
                   && (pin.addr[18:2] == JTAG_PATTERN); // RL6
        a32_hit  = (cls == AM_A32) && vopt_q[VOPT_A32_BIT] && pin.write_n
                   && (pin.addr[31:23] == a32_q[31:A32_BASE_LSB]); // RL22
        ofs_known = 1'b1;
        rword     = 32'h0;
        case (ofs)
            OFS_BOARD_IDENTITY: begin
                rword = crate_q & WM_BOARD_IDENTITY; // RL11
                rword[ID_A24_LSB +: 5] = geo; // RL11
                rword[ID_RUN_BIT] = run_mode_in; // RL12
                rword[ID_MODE_LSB +: 2] = run_mode_in ? MODE_RUNNING : 2'h0; // RL12
                rword[ID_TYPE_LSB +: 16] = BOARD_TYPE; // RL13
            end
            OFS_OPTIC:   rword = optic_q;
            OFS_IRQ:     rword = irq_q;
            OFS_TRIG:    rword = trig_q;
            OFS_A32:     rword = a32_q;
            OFS_BLOCK: begin
                rword = block_q;
                rword[BLK_USED_LSB +: 8] = block_level_in; // RL19
                rword[BLK_MASTER_LSB +: 8] = master_level_in; // RL19
            end
            OFS_FORMAT:  rword = format_q;
            OFS_VME_OPT: rword = vopt_q;
            OFS_CLK_SEL: rword = clksel_q;
            default:     ofs_known = 1'b0;
        endcase
        reg_hit = (cls == AM_A24) && base_ok && (pin.addr[18:8] == 11'h0)
                  && ofs_known; // RL10
    end

    // bus cycle state machine and register file
    always_comb begin
        st_d         = st_q;
        crate_d      = crate_q;
        optic_d      = optic_q;
        irq_d        = irq_q;
        trig_d       = trig_q;
        a32_d        = a32_q;
        block_d      = block_q;
        format_d     = format_q;
        vopt_d       = vopt_q;
        clksel_d     = clksel_q;
        data_d       = data_out;
        data_oe_n_d  = data_oe_n_out;
        dtack_oe_n_d = dtack_oe_n_out;
        a32_rd_d     = 1'b0;
        jtag_go_d    = 1'b0;
        jtag_tms_d   = jtag_tms_q;
        jtag_tdi_d   = jtag_tdi_q;
        reg_wr       = 1'b0;
        case (st_q)
            ST_IDLE: begin
                if (strobe) begin
                    if (jtag_hit) begin
                        jtag_go_d    = 1'b1; // RL8
                        jtag_tms_d   = pin.data[JTAG_TMS_BIT]; // RL7
                        jtag_tdi_d   = pin.data[JTAG_TDI_BIT]; // RL7
                        dtack_oe_n_d = 1'b0;
                        st_d         = ST_ACK;
                    end else if (reg_hit) begin
                        // running mode freezes the register contents
                        reg_wr       = !pin.write_n && !run_mode_in; // RL12
                        data_d       = rword;
                        data_oe_n_d  = !pin.write_n;
                        dtack_oe_n_d = 1'b0;
                        st_d         = ST_ACK;
                    end else if (a32_hit) begin
                        // event words come from the readout path, not here
                        a32_rd_d     = 1'b1;
                        data_d       = 32'h0;
                        data_oe_n_d  = 1'b0;
                        dtack_oe_n_d = 1'b0;
                        st_d         = ST_ACK;
                    end else begin
                        st_d = ST_SKIP;
                    end
                end
            end
            ST_ACK: begin
                if (released) begin
                    data_oe_n_d  = 1'b1;
                    dtack_oe_n_d = 1'b1;
                    st_d         = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (released) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                data_oe_n_d  = 1'b1;
                dtack_oe_n_d = 1'b1;
                st_d         = ST_IDLE;
            end
        endcase
        if (reg_wr) begin
            case (ofs)
                OFS_BOARD_IDENTITY: crate_d  = wmerge(crate_q, pin.data, WM_BOARD_IDENTITY); // RL11
                OFS_OPTIC:    optic_d  = wmerge(optic_q, pin.data, WM_OPTIC); // RL14
                OFS_IRQ:      irq_d    = wmerge(irq_q, pin.data, WM_IRQ); // RL16
                OFS_TRIG:     trig_d   = wmerge(trig_q, pin.data, WM_TRIG); // RL17
                OFS_A32:      a32_d    = wmerge(a32_q, pin.data, WM_A32); // RL18
                OFS_BLOCK:    block_d  = wmerge(block_q, pin.data, WM_BLOCK); // RL19
                OFS_FORMAT:   format_d = wmerge(format_q, pin.data, WM_FORMAT); // RL20
                OFS_VME_OPT:  vopt_d   = wmerge(vopt_q, pin.data, WM_VME_OPT); // RL22
                OFS_CLK_SEL:  clksel_d = wmerge(clksel_q, pin.data, WM_CLK_SEL); // RL1
                default:      crate_d  = crate_q;
            endcase
        end
    end

    // board-level controls
    always_comb begin
        case (clksel_q[1:0])
            CLKSEL_SWITCH: clk_osc_d = pin.sw[SW_CLK_BIT]; // RL1
            CLKSEL_OSC:    clk_osc_d = 1'b1; // RL1
            default:       clk_osc_d = 1'b0; // RL1
        endcase
        rev_d     = pin.sw[SW_REV_BIT] && !pin.fallback; // RL3
        p0_trig_d = trigger_in && optic_q[OPT_P0_EN_BIT]; // RL15
        p0_sync_d = synchronous_reset_broadcast_in && optic_q[OPT_P0_EN_BIT]; // RL15
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q                            <= ST_IDLE;
            crate_q                         <= RV_BOARD_IDENTITY;
            optic_q                         <= RV_OPTIC;
            irq_q                           <= RV_IRQ;
            trig_q                          <= RV_TRIG;
            a32_q                           <= RV_A32;
            block_q                         <= RV_BLOCK;
            format_q                        <= RV_FORMAT;
            vopt_q                          <= RV_VME_OPT;
            clksel_q                        <= RV_CLK_SEL;
            data_out                        <= 32'h0;
            data_oe_n_out                   <= 1'b1;
            dtack_out                       <= 1'b0;
            dtack_oe_n_out                  <= 1'b1;
            a32_read_out                    <= 1'b0;
            jtag_go_q                       <= 1'b0;
            jtag_tms_q                      <= 1'b0;
            jtag_tdi_q                      <= 1'b0;
            clk_source_osc_out              <= 1'b1;
            config_revision_out             <= 1'b0;
            p0_trigger_out                  <= 1'b0;
            synchronous_reset_broadcast_out <= 1'b0;
        end else begin
            st_q                            <= st_d;
            crate_q                         <= crate_d;
            optic_q                         <= optic_d;
            irq_q                           <= irq_d;
            trig_q                          <= trig_d;
            a32_q                           <= a32_d;
            block_q                         <= block_d;
            format_q                        <= format_d;
            vopt_q                          <= vopt_d;
            clksel_q                        <= clksel_d;
            data_out                        <= data_d;
            data_oe_n_out                   <= data_oe_n_d;
            dtack_out                       <= 1'b0;
            dtack_oe_n_out                  <= dtack_oe_n_d;
            a32_read_out                    <= a32_rd_d;
            jtag_go_q                       <= jtag_go_d;
            jtag_tms_q                      <= jtag_tms_d;
            jtag_tdi_q                      <= jtag_tdi_d;
            clk_source_osc_out              <= clk_osc_d;
            config_revision_out             <= rev_d;
            p0_trigger_out                  <= p0_trig_d;
            synchronous_reset_broadcast_out <= p0_sync_d;
        end
    end

    // register bits driven straight from their flops
    assign optic_low_power_select_out = optic_q[OPT_LP_BIT]; // RL14
    assign optic_module_select_n_out  = optic_q[OPT_MS_BIT]; // RL14
    assign optic_reset_n_out          = optic_q[OPT_RST_BIT]; // RL14
    assign cfg_out = '{irq_enable:  irq_q[16], // RL16
                       irq_level:   irq_q[10:8],
                       irq_vector:  irq_q[7:0],
                       trig_timing: trig_q, // RL17
                       a32_base:    a32_q[31:23], // RL18
                       a32_min:     a32_q[22:14],
                       a32_max:     a32_q[13:5],
                       block_size:  block_q[7:0],
                       format:      format_q[5:0], // RL21
                       vme_options: vopt_q[7:0]};
endmodule

// >>> src/vme_cfg_pkg.sv
// constants, types and helpers for the vme slave configuration front end
// assumes one 40 mhz clock and a synchronous active-low reset
// Overview of operation
// RL1: oscillator when switch high, panel otherwise, software override
// RL2: a24 base from geo lines or switch
// RL3: revision switch, fall back to revision zero
// RL4: accept jtag, a24 register, a32 block modifiers
// RL5: jtag port answers four user modifiers only
// RL6: jtag address: geo match plus fixed pattern
// RL7: data bit1 drives tdi, bit0 tms
// RL8: one test clock pulse per jtag write
// RL9: host avoids jtag address for registers
// RL10: registers use a24 d32 geo-matched base
// RL11: crate number writable, a24 base readable
// RL12: running mode reads 10 and blocks writes
// RL13: fixed board type code in top half
// RL14: transceiver low power, select, reset bits
// RL15: bit8 gates trigger and sync reset outputs
// RL16: interrupt vector, level, enable with defaults
// RL17: four timing fields, (n+1) times 4 ns
// RL18: a32 window max, min, base fields
// RL19: block size store plus two read-only levels
// RL20: two-bit event format field
// RL21: primitive, external and raw readout enables
// RL22: vme option bits, default 0x011
// RL23: host selects clock, loads table, initialises
package vme_cfg_pkg;
    localparam logic [7:0]  OFS_BOARD_IDENTITY   = 8'h00;
    localparam logic [7:0]  OFS_OPTIC      = 8'h04;
    localparam logic [7:0]  OFS_IRQ        = 8'h08;
    localparam logic [7:0]  OFS_TRIG       = 8'h0c;
    localparam logic [7:0]  OFS_A32        = 8'h10;
    localparam logic [7:0]  OFS_BLOCK      = 8'h14;
    localparam logic [7:0]  OFS_FORMAT     = 8'h18;
    localparam logic [7:0]  OFS_VME_OPT    = 8'h1c;
    localparam logic [7:0]  OFS_CLK_SEL    = 8'h2c;
    localparam logic [31:0] WM_BOARD_IDENTITY    = 32'h0000_00ff;
    localparam logic [31:0] WM_OPTIC       = 32'h0000_010e;
    localparam logic [31:0] WM_IRQ         = 32'h0001_07ff;
    localparam logic [31:0] WM_TRIG        = 32'hffff_ffff;
    localparam logic [31:0] WM_A32         = 32'hffff_ffe0;
    localparam logic [31:0] WM_BLOCK       = 32'h0000_00ff;
    localparam logic [31:0] WM_FORMAT      = 32'h0000_003f;
    localparam logic [31:0] WM_VME_OPT     = 32'h0000_009f;
    localparam logic [31:0] WM_CLK_SEL     = 32'h0000_0003;
    localparam logic [31:0] RV_BOARD_IDENTITY    = 32'h0000_0000;
    localparam logic [31:0] RV_OPTIC       = 32'h0000_010c;
    localparam logic [31:0] RV_IRQ         = 32'h0000_05c8;
    localparam logic [31:0] RV_TRIG        = 32'h0707_0707;
    localparam logic [31:0] RV_A32         = 32'h8000_3fe0;
    localparam logic [31:0] RV_BLOCK       = 32'h0000_0001;
    localparam logic [31:0] RV_FORMAT      = 32'h0000_0003;
    localparam logic [31:0] RV_VME_OPT     = 32'h0000_0011;
    localparam logic [31:0] RV_CLK_SEL     = 32'h0000_0000;
    // arbitrary board type value
    localparam logic [15:0] BOARD_TYPE     = 16'h5a00;
    localparam logic [1:0]  MODE_RUNNING   = 2'h2;
    localparam int          ID_A24_LSB     = 8;
    localparam int          ID_RUN_BIT     = 13;
    localparam int          ID_MODE_LSB    = 14;
    localparam int          ID_TYPE_LSB    = 16;
    localparam int          OPT_LP_BIT     = 1;
    localparam int          OPT_MS_BIT     = 2;
    localparam int          OPT_RST_BIT    = 3;
    localparam int          OPT_P0_EN_BIT  = 8;
    localparam int          BLK_USED_LSB   = 16;
    localparam int          BLK_MASTER_LSB = 24;
    localparam int          VOPT_A32_BIT   = 4;
    localparam int          A32_BASE_LSB   = 23;
    localparam int          SW_CLK_BIT     = 7;
    localparam int          SW_A24_BIT     = 6;
    localparam int          SW_REV_BIT     = 5;
    localparam int          JTAG_TDI_BIT   = 1;
    localparam int          JTAG_TMS_BIT   = 0;
    localparam logic [16:0] JTAG_PATTERN   = 17'h03fff;
    localparam logic [1:0]  CLKSEL_SWITCH  = 2'h0;
    localparam logic [1:0]  CLKSEL_OSC     = 2'h3;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam int          TCK_HIGH_NS    = 50;
    localparam logic [2:0]  TCK_HIGH_CYC   =
        3'((TCK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {AM_NONE, AM_JTAG, AM_A24, AM_A32} am_class_t;

    typedef struct packed {
        logic        as_n;
        logic [1:0]  ds_n;
        logic        write_n;
        logic [5:0]  am;
        logic [31:2] addr;
        logic [31:0] data;
        logic [4:0]  ga_n;
        logic [7:0]  sw;
        logic        fallback;
    } pin_t;

    localparam pin_t PIN_IDLE = '{as_n: 1'b1, ds_n: 2'h3, write_n: 1'b1,
        am: 6'h00, addr: 30'h0, data: 32'h0, ga_n: 5'h1f, sw: 8'hff,
        fallback: 1'b0};

    typedef struct packed {
        logic        irq_enable;
        logic [2:0]  irq_level;
        logic [7:0]  irq_vector;
        logic [31:0] trig_timing;
        logic [8:0]  a32_base;
        logic [8:0]  a32_min;
        logic [8:0]  a32_max;
        logic [7:0]  block_size;
        logic [5:0]  format;
        logic [7:0]  vme_options;
    } cfg_t;

    function automatic am_class_t am_class(input logic [5:0] am);
        case (am)
            6'h19, 6'h1a, 6'h1d, 6'h1e: am_class = AM_JTAG;
            6'h39, 6'h3a, 6'h3d, 6'h3e: am_class = AM_A24;
            6'h08, 6'h09, 6'h0b, 6'h0c, 6'h0d, 6'h0f: am_class = AM_A32;
            default: am_class = AM_NONE;
        endcase
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [31:0] mask);
        wmerge = (nw & mask) | (old & ~mask);
    endfunction
endpackage

// >>> src/pin_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes the bundle is quasi-static around each sampled strobe
`timescale 1ns/10ps
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= RST_VAL;
            q_out  <= RST_VAL;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule

// >>> src/jtag_step.sv
// emergency jtag driver: one tck pulse per accepted write
// assumes steps arrive no faster than one vme cycle apart
`timescale 1ns/10ps
module jtag_step
    import vme_cfg_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic step_in,
    input  wire logic tms_in,
    input  wire logic tdi_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    logic [2:0] cnt_q, cnt_d;
    logic       tck_d, tms_d, tdi_d;

    always_comb begin
        cnt_d = cnt_q;
        tms_d = tms_out;
        tdi_d = tdi_out;
        if (step_in && cnt_q == 3'h0) begin
            tms_d = tms_in; // RL7
            tdi_d = tdi_in; // RL7
            cnt_d = TCK_HIGH_CYC + 3'h1;
        end else if (cnt_q != 3'h0) begin
            cnt_d = cnt_q - 3'h1;
        end
        // setup cycle, then tck high, then low
        tck_d = (cnt_d != 3'h0) && (cnt_d <= TCK_HIGH_CYC); // RL8
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q   <= 3'h0;
            tck_out <= 1'b0;
            tms_out <= 1'b0;
            tdi_out <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            tck_out <= tck_d;
            tms_out <= tms_d;
            tdi_out <= tdi_d;
        end
    end
endmodule

// >>> tb/vme_cfg_checker_assertions.sv
// assertions on the ports of the vme slave configuration front end
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/10ps
module vme_cfg_checker (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        as_n_in,
    input wire logic [1:0]  ds_n_in,
    input wire logic        write_n_in,
    input wire logic [5:0]  am_in,
    input wire logic [31:0] data_in,
    input wire logic        trigger_in,
    input wire logic        synchronous_reset_broadcast_in,
    input wire logic        data_oe_n_out,
    input wire logic        dtack_oe_n_out,
    input wire logic        a32_read_out,
    input wire logic        jtag_tck_out,
    input wire logic        jtag_tms_out,
    input wire logic        jtag_tdi_out,
    input wire logic        p0_trigger_out,
    input wire logic        synchronous_reset_broadcast_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_tck_pulse_width: assert property (
        $rose(jtag_tck_out) |-> ##1 jtag_tck_out ##1 !jtag_tck_out) else $error("tck width");
    a_tck_levels_steady: assert property (
        jtag_tck_out |-> $stable(jtag_tms_out) && $stable(jtag_tdi_out)) else $error("tms moved");
    a_jtag_data_bits: assert property (
        $rose(jtag_tck_out) |-> jtag_tms_out == data_in[0] && jtag_tdi_out == data_in[1])
        else $error("jtag bits");
    a_jtag_user_am: assert property (
        $rose(jtag_tck_out) |-> !write_n_in && am_in[5:3] == 3'h3 && ^am_in[1:0])
        else $error("jtag am");
    a_p0_trigger_gate: assert property (
        p0_trigger_out |-> $past(trigger_in)) else $error("p0 trigger");
    a_p0_sync_gate: assert property (
        synchronous_reset_broadcast_out |-> $past(synchronous_reset_broadcast_in))
        else $error("p0 sync");
    a_ack_after_strobe: assert property (
        $fell(dtack_oe_n_out) |-> !as_n_in && $past(!as_n_in, 2)) else $error("early ack");
    a_ack_release: assert property (
        (ds_n_in == 2'h3) [*5] |-> dtack_oe_n_out && data_oe_n_out) else $error("ack held");
    a_drive_on_read: assert property (
        !data_oe_n_out |-> write_n_in) else $error("drive on write");
    a_a32_read_class: assert property (
        a32_read_out |-> write_n_in && am_in[5:3] == 3'h1) else $error("a32 class");
    cover property ($rose(jtag_tck_out));
    cover property (a32_read_out);
    cover property ($fell(dtack_oe_n_out) && !write_n_in);
endmodule

// >>> tb/vme_host_model.sv
// vme host model: single-word cycles on the slave's pins
// assumes the slave answers within eight clock cycles or not at all
`timescale 1ns/10ps
module vme_host_model
    import vme_cfg_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        dtack_oe_n_in,
    input  wire logic [31:0] rd_in,
    output pin_t             bus_out
);
    initial bus_out = PIN_IDLE;
    task automatic xfer(input logic wr, input logic [5:0] am, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q, output logic ack);
        int n;
        @(posedge clk_in);
        bus_out <= '{1'b0, 2'h0, !wr, am, a[31:2], d, 5'h1f, 8'hff, 1'b0};
        for (n = 0; dtack_oe_n_in && n < 8; n++) @(posedge clk_in);
        ack = !dtack_oe_n_in;
        q = rd_in;
        bus_out.as_n <= 1'b1;
        bus_out.ds_n <= 2'h3;
        while (!dtack_oe_n_in && n < 16) begin
            @(posedge clk_in);
            n++;
        end
        // released lines must not keep their last value
        bus_out.addr <= ~a[31:2];
        bus_out.data <= ~d;
        repeat (3) @(posedge clk_in);
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the vme slave configuration front end
// assumes the host model owns the strobes; the bench owns switches and levels
`timescale 1ns/10ps
module tb_top
    import vme_cfg_pkg::*;
;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, fb = 1'b0, run = 1'b0, ack;
    logic [7:0]  sw = 8'h80;
    logic [31:0] rdata, q, dout, base = 32'h0028_0000, tck_cnt = 32'h0;
    logic        dack_n, dtk, tck, tms, tdi, lp, ms_n, orst_n, osc, rev, p0t, p0s;
    int          fails = 0, cmp_count = 0, cyc = 0;
    pin_t        bus;
    cfg_t        cfg;
    logic [5:0]  jam [4] = '{6'h19, 6'h1a, 6'h1d, 6'h1e};
    logic [7:0]  ofs [8] = '{OFS_BOARD_IDENTITY, OFS_OPTIC, OFS_IRQ, OFS_TRIG, OFS_A32,
                             OFS_BLOCK, OFS_FORMAT, OFS_VME_OPT};
    logic [31:0] rv [8] = '{{BOARD_TYPE, 16'h0500}, RV_OPTIC, RV_IRQ, RV_TRIG, RV_A32,
                            RV_BLOCK | 32'hc33c_0000, RV_FORMAT, RV_VME_OPT};
    logic [31:0] wm [8] = '{WM_BOARD_IDENTITY, WM_OPTIC, WM_IRQ, WM_TRIG, WM_A32, WM_BLOCK,
                            WM_FORMAT, WM_VME_OPT};
    vme_host_model host (.clk_in(clk_in), .dtack_oe_n_in(dack_n), .rd_in(dout), .bus_out(bus));
    vme_slave_config DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .as_n_in(bus.as_n),
        .ds_n_in(bus.ds_n), .write_n_in(bus.write_n), .am_in(bus.am), .addr_in(bus.addr),
        .data_in(bus.data), .ga_n_in(~5'h05), .mode_switch_in(sw),
        .fallback_revision_select_in(fb), .run_mode_in(run), .block_level_in(8'h3c),
        .master_level_in(8'hc3), .trigger_in(!run), .synchronous_reset_broadcast_in(run),
        .data_out(dout), .data_oe_n_out(), .dtack_out(dtk), .dtack_oe_n_out(dack_n),
        .a32_read_out(), .jtag_tck_out(tck), .jtag_tms_out(tms), .jtag_tdi_out(tdi),
        .clk_source_osc_out(osc), .config_revision_out(rev), .optic_low_power_select_out(lp),
        .optic_module_select_n_out(ms_n), .optic_reset_n_out(orst_n), .p0_trigger_out(p0t),
        .synchronous_reset_broadcast_out(p0s), .cfg_out(cfg));
    initial forever #12.5 clk_in = ~clk_in;
    always @(posedge tck) tck_cnt <= tck_cnt + 32'h1;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_rw(input logic wr, input logic [7:0] o, input logic [31:0] d);
        host.xfer(wr, 6'h39, base | {24'h0, o}, d, rdata, ack);
    endtask
    task automatic rd(input logic [7:0] o, input logic [31:0] exp);
        reg_rw(1'b0, o, 32'h0);
        chk({ack, rdata}, {1'b1, exp});
    endtask
    task automatic close_out;
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        reg_rw(1'b1, OFS_CLK_SEL, RV_CLK_SEL);
        for (int i = 0; i < 8; i++) rd(ofs[i], rv[i]);
        chk({dtk, lp, ms_n, orst_n, osc, rev, p0t, p0s}, 8'h3a);
        chk({cfg.irq_enable, cfg.irq_level, cfg.irq_vector}, 12'h5c8);
        for (int i = 0; i < 8; i++) begin
            reg_rw(1'b1, ofs[i], 32'hffff_ffff);
            rd(ofs[i], rv[i] | wm[i]);
        end
        run <= 1'b1;
        reg_rw(1'b1, OFS_IRQ, 32'h0);
        rd(OFS_IRQ, RV_IRQ | WM_IRQ);
        rd(OFS_BOARD_IDENTITY, rv[0] | 32'h0000_a0ff);
        chk({lp, ms_n, orst_n, p0t, p0s}, 5'h1d);
        run <= 1'b0;
        reg_rw(1'b1, OFS_OPTIC, 32'h0);
        chk({lp, ms_n, orst_n, p0t, p0s}, 5'h0);
        reg_rw(1'b1, OFS_CLK_SEL, 32'h1);
        chk(osc, 1'b0);
        reg_rw(1'b1, OFS_CLK_SEL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, jam[i], 32'ha500_fffc | base, 32'(i), q, ack);
            chk({ack, tms, tdi}, {1'b1, i[0], i[1]});
        end
        host.xfer(1'b1, 6'h39, base | 32'hfffc, 32'h3, q, ack);
        chk({ack, tck_cnt}, {1'b0, 32'h4});
        host.xfer(1'b1, 6'h19, 32'h0030_fffc, 32'h3, q, ack);
        chk({ack, tck_cnt}, {1'b0, 32'h4});
        host.xfer(1'b0, 6'h09, 32'hff80_0000, 32'h0, q, ack);
        chk({ack, q}, {1'b1, 32'h0});
        sw <= 8'h6a;
        base = 32'h0050_0000;
        repeat (4) @(posedge clk_in);
        rd(OFS_BOARD_IDENTITY, {BOARD_TYPE, 16'h0aff});
        chk({osc, rev}, 2'h1);
        fb <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(rev, 1'b0);
        close_out();
    end
endmodule
bind vme_slave_config vme_cfg_checker u_chk (.*);
